// *** core/asp_pkg.sv ***
package asp_pkg;

   // Master clock and output rate
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned DEF_RATE_SPS   = 1000;
   localparam int unsigned PERIOD_CLKS    = CLK_HZ / DEF_RATE_SPS;

   // Settling latency: 62.98046875 output periods is 16123/256 of them
   localparam int unsigned LAT_NUM        = 16123;
   localparam int unsigned LAT_DEN        = 256;
   localparam int unsigned LAT_EXTRA_CLKS = 468;
   localparam int unsigned FIR_LAT_CLKS   =
      (LAT_NUM * PERIOD_CLKS + LAT_DEN - 1) / LAT_DEN + LAT_EXTRA_CLKS;
   localparam int unsigned WAKE_SHORT_CLKS = 2;
   localparam int unsigned SYNC_LAT_CLKS  = 3;
   localparam int unsigned WAKE_LAT_CLKS  = FIR_LAT_CLKS - WAKE_SHORT_CLKS - SYNC_LAT_CLKS;

   // Power-on reset count
   localparam int unsigned POR_CLKS       = 65536;

   // Ready strobe and port timeout
   localparam int unsigned STROBE_CLKS    = 4;
   localparam int unsigned TMO_PERIODS    = 64;
   localparam int unsigned TMO_W          = 7;

   // Widths
   localparam int unsigned CNT_W          = 20;
   localparam int unsigned WORD_W         = 32;
   localparam int unsigned CMD_W          = 8;

   // Command opcodes, values arbitrary
   localparam logic [7:0] CMD_RESUME      = 8'h01;
   localparam logic [7:0] CMD_STANDBY     = 8'h02;
   localparam logic [7:0] CMD_CONT_READ   = 8'h03;
   localparam logic [7:0] CMD_STOP_CONT   = 8'h04;
   localparam logic [7:0] CMD_READ_DATA   = 8'h05;

   // Synchroniser lanes into the master clock domain
   localparam int unsigned SY_PD          = 0;
   localparam int unsigned SY_CS          = 1;
   localparam int unsigned SY_WAKE        = 2;
   localparam int unsigned SY_STBY        = 3;
   localparam int unsigned SY_RD          = 4;
   localparam int unsigned SY_ACT         = 5;
   localparam int unsigned SY_N           = 6;
   localparam logic [5:0]  SY_RST         = 6'h03;

   // Power states, Gray along POR, SETTLE, RUN, STANDBY, DOWN
   typedef enum logic [2:0] {
      ST_POR    = 3'h0,
      ST_SETTLE = 3'h1,
      ST_RUN    = 3'h3,
      ST_STBY   = 3'h2,
      ST_DOWN   = 3'h6
   } asp_state_t;

endpackage

// *** core/asp_tim_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface asp_tim_if;
   logic restart;
   logic wake;
   logic run;
   logic update;
   logic strobe_hi;

   modport ctl (output restart, output wake, output run, input update, input strobe_hi);
   modport gen (input restart, input wake, input run, output update, output strobe_hi);
endinterface
`default_nettype wire

// *** core/asp_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_timer #(
   parameter int unsigned PERIOD   = asp_pkg::PERIOD_CLKS,
   parameter int unsigned FIR_LAT  = asp_pkg::FIR_LAT_CLKS,
   parameter int unsigned WAKE_LAT = asp_pkg::WAKE_LAT_CLKS,
   parameter int unsigned CW       = asp_pkg::CNT_W
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Sequencer side
   asp_tim_if.gen   tim
);
   logic [CW-1:0] cnt_q;
   logic          live_q;
   logic          update_q;
   logic          strobe_q;

   wire           ticking   = live_q & tim.run & ~tim.restart;
   wire           at_zero   = (cnt_q == '0);
   wire           live_d    = tim.restart | (live_q & tim.run);
   wire [CW-1:0]  first_cnt = tim.wake ? CW'(WAKE_LAT - 1) : CW'(FIR_LAT - 1);
   wire [CW-1:0]  step_cnt  = at_zero ? CW'(PERIOD - 1) : cnt_q - 1'b1;
   wire [CW-1:0]  cnt_d     = tim.restart ? first_cnt : (ticking ? step_cnt : cnt_q);
   // Strobe covers the four clocks just before each update
   wire           strobe_d  = live_d & tim.run & (cnt_d < CW'(asp_pkg::STROBE_CLKS));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q    <= '0;
         live_q   <= 1'b0;
         update_q <= 1'b0;
         strobe_q <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         live_q   <= live_d;
         update_q <= ticking & at_zero;
         strobe_q <= strobe_d;
      end
   end

   assign tim.update    = update_q;
   assign tim.strobe_hi = strobe_q;
endmodule
`default_nettype wire

// *** core/asp_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_top #(
   parameter int unsigned POR_CLKS     = asp_pkg::POR_CLKS,
   parameter int unsigned PERIOD_CLKS  = asp_pkg::PERIOD_CLKS,
   parameter int unsigned FIR_LAT_CLKS = asp_pkg::FIR_LAT_CLKS
)(
   // Master clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // Power-down pin
   input  wire logic                      power_down_pin_n,
   // Serial port
   input  wire logic                      sclk,
   input  wire logic                      cs_n,
   input  wire logic                      din,
   output var  logic                      dout,
   output var  logic                      dout_oe,
   // Conversion ready
   output var  logic                      conversion_ready_n,
   // Converter core side
   input  wire logic [asp_pkg::WORD_W-1:0] result_word,
   output var  logic                      circuit_en,
   output var  logic                      cfg_clear,
   output var  logic                      conv_running,
   output var  logic                      filter_fir,
   output var  logic                      rate_default
);
   localparam int unsigned WAKE_LAT = FIR_LAT_CLKS - asp_pkg::WAKE_SHORT_CLKS
                                      - asp_pkg::SYNC_LAT_CLKS;
   localparam int unsigned POR_W    = $clog2(POR_CLKS + 1);
   localparam int unsigned W        = asp_pkg::WORD_W;
   localparam int unsigned N        = asp_pkg::SY_N;

   function automatic logic cmd_hit(input logic [7:0] rx, input logic [7:0] op);
      cmd_hit = (rx == op);
   endfunction

   // ---------------- Master clock domain ----------------
   asp_tim_if tim ();

   asp_timer #(
      .PERIOD   (PERIOD_CLKS),
      .FIR_LAT  (FIR_LAT_CLKS),
      .WAKE_LAT (WAKE_LAT),
      .CW       (asp_pkg::CNT_W)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tim     (tim)
   );

   asp_pkg::asp_state_t       state_q;
   asp_pkg::asp_state_t       state_d;
   logic [N-1:0]              sy1_q;
   logic [N-1:0]              sy2_q;
   logic [N-1:0]              sy3_q;
   logic [N-1:0]              acc_q;
   logic [POR_W-1:0]          por_q;
   logic [asp_pkg::TMO_W-1:0] tmo_cnt_q;
   logic                      tmo_q;
   logic                      hold_q;
   logic [W-1:0]              data_q;
   logic                      conversion_ready_n_n_q;
   logic                      restart_q;
   logic                      wake_q;
   logic                      run_q;
   logic                      en_q;
   logic                      clr_q;
   logic                      running_q;
   logic                      fir_q;
   logic                      rate_q;
   logic                      restart_d;
   logic                      wake_d;

   // Link-domain signals seen here
   logic                      act_tg_q;
   logic                      rd_tg_q;
   logic                      stby_tg_q;
   logic                      wake_tg_q;

   wire [N-1:0] sy_raw    = {act_tg_q, rd_tg_q, stby_tg_q, wake_tg_q, cs_n, power_down_pin_n};
   // A change counts once stages two and three agree
   wire [N-1:0] sy_chg    = (sy2_q ~^ sy3_q) & (sy3_q ^ acc_q);
   wire         pd_down   = ~acc_q[asp_pkg::SY_PD];
   wire         cs_high   = acc_q[asp_pkg::SY_CS];
   wire         wake_evt  = sy_chg[asp_pkg::SY_WAKE];
   wire         stby_evt  = sy_chg[asp_pkg::SY_STBY];
   wire         rd_evt    = sy_chg[asp_pkg::SY_RD];
   wire         act_evt   = sy_chg[asp_pkg::SY_ACT];
   wire         por_done  = (por_q == POR_W'(POR_CLKS - 1));
   wire         tmo_last  = (tmo_cnt_q == asp_pkg::TMO_W'(asp_pkg::TMO_PERIODS - 1));
   wire         run_d     = (state_d == asp_pkg::ST_SETTLE) || (state_d == asp_pkg::ST_RUN);
   wire         hold_d    = (state_d == asp_pkg::ST_POR) || (state_d == asp_pkg::ST_DOWN);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sy1_q <= asp_pkg::SY_RST;
         sy2_q <= asp_pkg::SY_RST;
         sy3_q <= asp_pkg::SY_RST;
         acc_q <= asp_pkg::SY_RST;
      end else begin
         sy1_q <= sy_raw;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         acc_q <= acc_q ^ sy_chg;
      end
   end

   always_comb begin
      state_d   = state_q;
      restart_d = 1'b0;
      wake_d    = 1'b0;
      if (pd_down && state_q != asp_pkg::ST_POR) begin
         state_d = asp_pkg::ST_DOWN;
      end else begin
         case (state_q)
            asp_pkg::ST_POR: begin
               if (por_done) begin
                  state_d   = asp_pkg::ST_SETTLE;
                  restart_d = 1'b1;
               end
            end
            asp_pkg::ST_DOWN: begin
               state_d   = asp_pkg::ST_SETTLE;
               restart_d = 1'b1;
            end
            asp_pkg::ST_SETTLE: begin
               if (stby_evt) begin
                  state_d = asp_pkg::ST_STBY;
               end else if (tim.update) begin
                  state_d = asp_pkg::ST_RUN;
               end
            end
            asp_pkg::ST_RUN: begin
               if (stby_evt) begin
                  state_d = asp_pkg::ST_STBY;
               end
            end
            asp_pkg::ST_STBY: begin
               if (wake_evt || cs_high) begin
                  state_d   = asp_pkg::ST_SETTLE;
                  restart_d = 1'b1;
                  wake_d    = 1'b1;
               end
            end
            default: begin
               state_d = asp_pkg::ST_POR;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q   <= asp_pkg::ST_POR;
         por_q     <= '0;
         restart_q <= 1'b0;
         wake_q    <= 1'b0;
         run_q     <= 1'b0;
         hold_q    <= 1'b1;
         en_q      <= 1'b0;
         running_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         por_q     <= (state_q == asp_pkg::ST_POR) ? por_q + 1'b1 : '0;
         restart_q <= restart_d;
         wake_q    <= wake_d;
         run_q     <= run_d;
         hold_q    <= hold_d;
         en_q      <= run_d;
         running_q <= (state_d == asp_pkg::ST_RUN);
      end
   end

   // Configuration defaults
   always_ff @(posedge sys_clk) begin
      if (rst || pd_down) begin
         clr_q  <= 1'b1;
         fir_q  <= 1'b1;
         rate_q <= 1'b1;
      end else begin
         clr_q  <= 1'b0;
         fir_q  <= fir_q;
         rate_q <= rate_q;
      end
   end

   assign tim.restart = restart_q;
   assign tim.wake    = wake_q;
   assign tim.run     = run_q;

   // Result capture and ready output
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_q   <= '0;
         conversion_ready_n_n_q <= 1'b1;
      end else begin
         if (tim.update) begin
            data_q <= result_word;
         end
         if (!run_q) begin
            conversion_ready_n_n_q <= 1'b1;
         end else if (tim.update) begin
            conversion_ready_n_n_q <= 1'b0;
         end else if (rd_evt || tim.strobe_hi) begin
            conversion_ready_n_n_q <= 1'b1;
         end
      end
   end

   // Port timeout counted in ready periods
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tmo_cnt_q <= '0;
         tmo_q     <= 1'b0;
      end else if (act_evt || cs_high) begin
         tmo_cnt_q <= '0;
         tmo_q     <= 1'b0;
      end else if (tim.update) begin
         tmo_cnt_q <= tmo_last ? '0 : tmo_cnt_q + 1'b1;
         tmo_q     <= tmo_last;
      end else begin
         tmo_q     <= 1'b0;
      end
   end

   assign conversion_ready_n = conversion_ready_n_n_q;
   assign circuit_en         = en_q;
   assign cfg_clear          = clr_q;
   assign conv_running       = running_q;
   assign filter_fir         = fir_q;
   assign rate_default       = rate_q;

   // ---------------- Serial clock domain ----------------
   logic [2:0]   bit_q;
   logic [6:0]   sh_q;
   logic         started_q;
   logic         load_q;
   logic         cont_q;
   logic [W-1:0] word_q;
   logic [W-2:0] tx_q;
   logic         dout_q;
   logic         oe_q;

   // Chip select, timeout or power-down clear the port asynchronously
   wire         link_clr  = cs_n | tmo_q | hold_q;
   wire         mode_set  = cs_n | hold_q;
   wire [7:0]   byte_in   = {sh_q, din};
   wire         byte_done = (bit_q == 3'h7);
   wire         hit_wake  = byte_done & cmd_hit(byte_in, asp_pkg::CMD_RESUME);
   wire         hit_stby  = byte_done & cmd_hit(byte_in, asp_pkg::CMD_STANDBY);
   wire         hit_cont  = byte_done & cmd_hit(byte_in, asp_pkg::CMD_CONT_READ);
   wire         hit_stop  = byte_done & cmd_hit(byte_in, asp_pkg::CMD_STOP_CONT);
   wire         hit_read  = byte_done & cmd_hit(byte_in, asp_pkg::CMD_READ_DATA);
   wire         load_now  = (~started_q & cont_q) | (hit_read & ~cont_q);

   always_ff @(posedge sclk or posedge link_clr) begin
      if (link_clr) begin
         bit_q     <= 3'h0;
         sh_q      <= 7'h00;
         started_q <= 1'b0;
         load_q    <= 1'b0;
      end else begin
         bit_q     <= bit_q + 3'h1;
         sh_q      <= byte_in[6:0];
         started_q <= 1'b1;
         load_q    <= load_now;
      end
   end

   // Private copy keeps a command read intact across an update
   always_ff @(posedge sclk) begin
      if (load_now) begin
         word_q <= data_q;
      end
   end

   always_ff @(posedge sclk or posedge mode_set) begin
      if (mode_set) begin
         cont_q <= 1'b1;
      end else if (hit_stop) begin
         cont_q <= 1'b0;
      end else if (hit_cont) begin
         cont_q <= 1'b1;
      end
   end

   // Event toggles toward the master clock domain
   always_ff @(posedge sclk or posedge hold_q) begin
      if (hold_q) begin
         act_tg_q  <= 1'b0;
         wake_tg_q <= 1'b0;
         stby_tg_q <= 1'b0;
      end else if (!link_clr) begin
         act_tg_q  <= ~act_tg_q;
         wake_tg_q <= wake_tg_q ^ hit_wake;
         stby_tg_q <= stby_tg_q ^ hit_stby;
      end
   end

   always_ff @(negedge sclk or posedge link_clr) begin
      if (link_clr) begin
         tx_q   <= '0;
         dout_q <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         oe_q <= 1'b1;
         if (load_q) begin
            dout_q <= word_q[W-1];
            tx_q   <= word_q[W-2:0];
         end else begin
            dout_q <= tx_q[W-2];
            tx_q   <= {tx_q[W-3:0], 1'b0};
         end
      end
   end

   always_ff @(negedge sclk or posedge hold_q) begin
      if (hold_q) begin
         rd_tg_q <= 1'b0;
      end else if (load_q) begin
         rd_tg_q <= ~rd_tg_q;
      end
   end

   assign dout    = dout_q;
   assign dout_oe = oe_q;
endmodule
`default_nettype wire

// *** tb/asp_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_props #(
   parameter int unsigned POR_CLKS    = asp_pkg::POR_CLKS,
   parameter int unsigned PERIOD_CLKS = asp_pkg::PERIOD_CLKS
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pins
   input wire logic power_down_pin_n,
   input wire logic cs_n,
   input wire logic dout_oe,
   input wire logic conversion_ready_n,
   // Core side
   input wire logic circuit_en,
   input wire logic cfg_clear,
   input wire logic conv_running,
   input wire logic filter_fir,
   input wire logic rate_default
);
   logic [31:0] por_q;
   logic [31:0] per_q;
   logic [31:0] low_q;
   logic        por_done;
   logic        quiet;

   assign por_done = (por_q >= POR_CLKS + 8);
   assign quiet    = por_done && power_down_pin_n && cs_n;

   // Cycles since reset, gap between ready falls, length of ready low
   always_ff @(posedge sys_clk) begin
      por_q <= rst ? 32'h0 : (por_done ? por_q : por_q + 32'h1);
      per_q <= $fell(conversion_ready_n) ? 32'h1 : per_q + 32'h1;
      low_q <= conversion_ready_n ? 32'h0 : low_q + 32'h1;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence pd_held_s;
      !power_down_pin_n [*6];
   endsequence
   sequence strobe_s;
      conversion_ready_n [*4] ##1 !conversion_ready_n;
   endsequence

   pd_clear_a: assert property (pd_held_s |-> cfg_clear && !circuit_en && !conv_running)
      else $error("power-down did not disable");
   cfg_keep_a: assert property (power_down_pin_n [*6] |-> !cfg_clear)
      else $error("configuration cleared with pin high");
   stby_idle_a: assert property (!circuit_en && $past(!circuit_en) |-> conversion_ready_n && !conv_running)
      else $error("ready or running with circuitry off");
   cs_wake_a: assert property (quiet [*8] |-> circuit_en)
      else $error("chip select high did not leave standby");
   por_hold_a: assert property (por_q < POR_CLKS |-> !circuit_en && conversion_ready_n)
      else $error("released before power-on count");
   dflt_sel_a: assert property ($fell(cfg_clear) |-> filter_fir && rate_default)
      else $error("default selection lost");
   cs_tristate_a: assert property (cs_n |-> !dout_oe)
      else $error("output driven with chip select high");
   ready_period_a: assert property ($fell(conversion_ready_n) && $past(conv_running)
      |-> per_q == PERIOD_CLKS)
      else $error("ready period wrong");
   ready_strobe_a: assert property ($rose(conversion_ready_n) && low_q == PERIOD_CLKS - 4
      |-> strobe_s)
      else $error("ready strobe not four cycles");
endmodule

bind asp_top asp_props #(.POR_CLKS(POR_CLKS), .PERIOD_CLKS(PERIOD_CLKS)) i_props (
   .sys_clk(sys_clk), .rst(rst), .power_down_pin_n(power_down_pin_n), .cs_n(cs_n),
   .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n), .circuit_en(circuit_en),
   .cfg_clear(cfg_clear), .conv_running(conv_running), .filter_fir(filter_fir),
   .rate_default(rate_default));
`default_nettype wire

// *** tb/asp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_host (
   // Master clock
   input  wire logic sys_clk,
   // Serial port
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end

   // Sends nb bits of tx, MSB first, and gathers dout at each rise
   task automatic xfer(input logic [39:0] tx, input int nb, input bit hold,
                       output logic [39:0] rx);
      rx = 40'h0;
      if (cs_n) begin
         @(negedge sys_clk);
         cs_n = 1'b0;
      end
      #20;
      for (int i = nb - 1; i >= 0; i--) begin
         din = tx[i];
         #7.5;
         sclk = 1'b1;
         rx = {rx[38:0], dout};
         #7.5;
         sclk = 1'b0;
      end
      din = 1'b0;
      #20;
      if (!hold) begin
         @(negedge sys_clk);
         cs_n = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/asp_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_top_tb;
   localparam int unsigned POR = 64;
   localparam int unsigned PER = 40;
   localparam int unsigned LAT = 100;

   logic        sys_clk, rst, power_down_pin_n, sclk, cs_n, din, dout, dout_oe;
   logic        conversion_ready_n, circuit_en, cfg_clear, conv_running;
   logic        filter_fir, rate_default;
   logic [31:0] result_word;
   logic [39:0] rx;
   int          bad_count;
   int          num_checks;
   int          n;
   // Released line reads high, the inverse of dout, which clears to 0 with the output enable
   wire         dout_line = dout_oe ? dout : ~dout;

   asp_top #(.POR_CLKS(POR), .PERIOD_CLKS(PER), .FIR_LAT_CLKS(LAT)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .power_down_pin_n(power_down_pin_n), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
      .conversion_ready_n(conversion_ready_n), .result_word(result_word),
      .circuit_en(circuit_en), .cfg_clear(cfg_clear), .conv_running(conv_running),
      .filter_fir(filter_fir), .rate_default(rate_default));

   asp_host i_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));

   always #50 sys_clk = ~sys_clk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_in(input string what, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Cycles until the ready output falls, bounded
   task automatic wait_fall(input int lim, output int cyc);
      logic prev;
      prev = conversion_ready_n;
      for (cyc = 1; cyc <= lim; cyc++) begin
         @(negedge sys_clk);
         if (prev === 1'b1 && conversion_ready_n === 1'b0) return;
         prev = conversion_ready_n;
      end
      bad_count++;
      $display("wrong value ready fall expected within %0d seen none", lim);
      close_out();
   endtask

   task automatic t_por;
      wait_fall(POR + LAT + 60, n);
      chk_in("power-on latency", POR + LAT - 3, POR + LAT + 12, n);
      chk("fir default", 32'h1, {31'h0, filter_fir});
      chk("rate default", 32'h1, {31'h0, rate_default});
      $display("test power-on done");
   endtask

   task automatic t_cont;
      wait_fall(2 * PER, n);
      i_host.xfer(40'h0, 33, 1'b0, rx);
      chk("stream word", 32'hc3a50f96, rx[31:0]);
      repeat (3) @(negedge sys_clk);
      chk("ready after read", 32'h1, {31'h0, conversion_ready_n});
      chk("oe after cs", 32'h0, {31'h0, dout_oe});
      $display("test stream done");
   endtask

   task automatic t_cmd;
      wait_fall(2 * PER, n);
      i_host.xfer(40'h04, 8, 1'b1, rx);
      @(negedge sys_clk);
      result_word = 32'h5a3ce187;
      wait_fall(2 * PER, n);
      // Next update lands inside the command read
      repeat (PER - 4) @(negedge sys_clk);
      result_word = 32'h96e1c35a;
      i_host.xfer(40'h0500000000, 40, 1'b0, rx);
      chk("command word", 32'h5a3ce187, rx[31:0]);
      wait_fall(2 * PER, n);
      wait_fall(2 * PER, n);
      i_host.xfer(40'h0, 33, 1'b0, rx);
      chk("stream after cs", 32'h96e1c35a, rx[31:0]);
      $display("test command read done");
   endtask

   task automatic t_stby;
      wait_fall(2 * PER, n);
      i_host.xfer(40'h02, 8, 1'b1, rx);
      repeat (8) @(negedge sys_clk);
      chk("standby circuit", 32'h0, {31'h0, circuit_en});
      chk("standby config", 32'h0, {31'h0, cfg_clear});
      i_host.xfer(40'h01, 8, 1'b1, rx);
      wait_fall(LAT + 60, n);
      chk_in("resume latency", LAT - 8, LAT + 2, n);
      i_host.xfer(40'h0, 0, 1'b0, rx);
      $display("test standby done");
   endtask

   task automatic t_power_down_pin_n;
      power_down_pin_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk("down config", 32'h1, {31'h0, cfg_clear});
      chk("down circuit", 32'h0, {31'h0, circuit_en});
      power_down_pin_n = 1'b1;
      wait_fall(LAT + 60, n);
      chk_in("pin latency", LAT - 3, LAT + 10, n);
      chk("fir after pin", 32'h1, {31'h0, filter_fir});
      $display("test power-down done");
   endtask

   task automatic t_tmo;
      wait_fall(2 * PER, n);
      i_host.xfer(40'h7, 3, 1'b1, rx);
      repeat (66 * PER) @(negedge sys_clk);
      i_host.xfer(40'h02, 8, 1'b1, rx);
      repeat (8) @(negedge sys_clk);
      chk("standby after timeout", 32'h0, {31'h0, circuit_en});
      i_host.xfer(40'h0, 0, 1'b0, rx);
      repeat (8) @(negedge sys_clk);
      chk("wake by cs", 32'h1, {31'h0, circuit_en});
      $display("test timeout done");
   endtask

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      power_down_pin_n = 1'b1;
      result_word = 32'hc3a50f96;
      bad_count = 0;
      num_checks = 0;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      t_por();
      t_cont();
      t_cmd();
      t_stby();
      t_power_down_pin_n();
      t_tmo();
      close_out();
   end
endmodule
`default_nettype wire
